// ==== src/psfd_cfg.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "psfd_params.svh"
module psfd_cfg
    import psfd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        main_reset_n,
    input  wire logic        strap_cnf0,
    input  wire logic        strap_cnf1,
    input  wire logic        strap_cnf2,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  module_activate,
    output logic      [3:0]  module_enable,
    output logic             global_enable_bit,
    output logic      [7:0]  pin_select
);
    psfd_state_type state;
    psfd_byte_type  fast_disable;
    psfd_byte_type  lock_ctrl;
    logic           main_sync1;
    logic           main_sync2;
    logic           main_prev;
    logic [2:0]     strap_sync1;
    logic [2:0]     strap_sync2;
    logic           strap_done;
    logic [1:0]     strap_age;
    logic           wr_take;
    logic           rd_take;
    logic           next_lock_clear;
    psfd_lock_if    lk ();

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `PSFD_ADDR_PIN_SELECT) ||
                 hit(a, `PSFD_ADDR_FAST_DISABLE) ||
                 hit(a, `PSFD_ADDR_LOCK_CONTROL) ||
                 hit(a, `PSFD_ADDR_GLOBAL_ENABLE);
    endfunction

    // slave answers one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PSFD_IDLE;
        end else begin
            case (state)
                PSFD_IDLE:   state <= (psel && penable) ? PSFD_ACCESS
                                                         : PSFD_IDLE;
                PSFD_ACCESS: state <= PSFD_IDLE;
                default:     state <= PSFD_IDLE;
            endcase
        end
    end

    assign wr_take = psel && penable && pready && pwrite && pstrb[0];
    assign rd_take = psel && penable && (state == PSFD_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_take;
            pslverr <= rd_take && !mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_take) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, `PSFD_ADDR_PIN_SELECT))
                prdata[7:0] <= pin_select;
            if (hit(paddr, `PSFD_ADDR_FAST_DISABLE))
                prdata[7:0] <= fast_disable;
            if (hit(paddr, `PSFD_ADDR_LOCK_CONTROL))
                prdata[7:0] <= lock_ctrl;
            if (hit(paddr, `PSFD_ADDR_GLOBAL_ENABLE))
                prdata[0] <= global_enable_bit;
        end
    end

    // main reset and straps are pins: two flip-flops each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_sync1  <= 1'b0;
            main_sync2  <= 1'b0;
            main_prev   <= 1'b0;
            strap_sync1 <= 3'b000;
            strap_sync2 <= 3'b000;
        end else begin
            main_sync1  <= main_reset_n;
            main_sync2  <= main_sync1;
            main_prev   <= main_sync2;
            strap_sync1 <= {strap_cnf2, strap_cnf1, strap_cnf0};
            strap_sync2 <= strap_sync1;
        end
    end

    // strap load after release
    // straps are caught once, when the sync chain holds the pin levels;
    // loading earlier would take the chain's reset zeros instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_select <= `PSFD_RST_PIN_SELECT;
            strap_done <= 1'b0;
            strap_age  <= 2'h0;
        end else if (!strap_done) begin
            strap_age <= strap_age + 2'h1;
            if (strap_age == `PSFD_STRAP_SETTLE) begin
                strap_done <= 1'b1;
                pin_select[`PSFD_BIT_STB2] <= !strap_sync2[2];
                pin_select[`PSFD_BIT_STB1] <= !strap_sync2[2];
                pin_select[`PSFD_BIT_STB0] <= !strap_sync2[2];
                pin_select[`PSFD_BIT_CS0]  <= strap_sync2[2] ? strap_sync2[0]
                                                              : 1'b0;
            end
        end else if (wr_take && hit(paddr, `PSFD_ADDR_PIN_SELECT)) begin
            pin_select <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ctrl <= `PSFD_RST_LOCK_CONTROL;
        end else if (wr_take && hit(paddr, `PSFD_ADDR_LOCK_CONTROL)) begin
            lock_ctrl <= pwdata[7:0] & `PSFD_MASK_LOCK_CONTROL;
        end else begin
            lock_ctrl[`PSFD_BIT_UNLOCK] <= 1'b0;
        end
    end

    // main power clear
    // falling edge of synced main reset clears the lock while the source select bit is 0
    assign next_lock_clear = lock_ctrl[`PSFD_BIT_UNLOCK] ||
        (!lock_ctrl[`PSFD_BIT_SRC_SELECT] && main_prev && !main_sync2);

    assign lk.set_req = wr_take && hit(paddr, `PSFD_ADDR_FAST_DISABLE) &&
                        pwdata[`PSFD_BIT_LOCK];
    assign lk.clear_req = next_lock_clear;

    psfd_lock_keeper u_keeper (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_disable <= `PSFD_RST_FAST_DISABLE;
        end else begin
            fast_disable[`PSFD_BIT_LOCK] <= lk.locked | lk.set_req;
            if (lk.clear_req)
                fast_disable[`PSFD_BIT_LOCK] <= 1'b0;
            if (wr_take && hit(paddr, `PSFD_ADDR_FAST_DISABLE)) begin
                fast_disable[6:5] <= pwdata[6:5];
                if (!lk.locked)
                    fast_disable[3:0] <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_enable_bit <= 1'b0;
        end else if (wr_take && hit(paddr, `PSFD_ADDR_GLOBAL_ENABLE) &&
                     !lk.locked) begin
            global_enable_bit <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_enable <= 4'h0;
        end else begin
            module_enable <= module_activate & ~fast_disable[3:0];
        end
    end

    property p_locked_hold;
        @(posedge pclk) disable iff (!presetn)
        lk.locked |=> $stable(fast_disable[3:0]);
    endproperty
    a_locked_hold: assert property (p_locked_hold)
        else $error("force-off bits changed while locked");

    property p_force_off;
        @(posedge pclk) disable iff (!presetn)
        fast_disable[0] |=> !module_enable[0];
    endproperty
    a_force_off: assert property (p_force_off)
        else $error("module enabled despite force-off");

    property p_lock_set;
        @(posedge pclk) disable iff (!presetn)
        (lk.set_req && !lk.clear_req) |=> fast_disable[`PSFD_BIT_LOCK];
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("lock did not set after write one");

    property p_global_frozen;
        @(posedge pclk) disable iff (!presetn)
        lk.locked |=> $stable(global_enable_bit);
    endproperty
    a_global_frozen: assert property (p_global_frozen)
        else $error("global enable changed while locked");
endmodule // psfd_cfg
`default_nettype wire

// ==== src/psfd_params.svh ====
`ifndef PSFD_PARAMS_SVH
`define PSFD_PARAMS_SVH
// register indices; byte address is four times the index
`define PSFD_IDX_PIN_SELECT      8'h25
`define PSFD_IDX_FAST_DISABLE    8'h26
`define PSFD_IDX_LOCK_CONTROL    8'h30
`define PSFD_IDX_GLOBAL_ENABLE   8'h31
// byte addresses
`define PSFD_ADDR_PIN_SELECT     12'h094
`define PSFD_ADDR_FAST_DISABLE   12'h098
`define PSFD_ADDR_LOCK_CONTROL   12'h0C0
`define PSFD_ADDR_GLOBAL_ENABLE  12'h0C4
// fast disable fields
`define PSFD_BIT_LOCK            7
`define PSFD_BIT_SCRATCH_HI      6
`define PSFD_BIT_SCRATCH_LO      5
`define PSFD_BIT_SER1            3
`define PSFD_BIT_SER2            2
`define PSFD_BIT_PARP            1
`define PSFD_BIT_FDC             0
// lock control fields
`define PSFD_BIT_SRC_SELECT      0
`define PSFD_BIT_UNLOCK          1
// pin select fields
`define PSFD_BIT_IRQ             7
`define PSFD_BIT_STB2            6
`define PSFD_BIT_STB1            5
`define PSFD_BIT_STB0            4
`define PSFD_BIT_CS0             0
// reset values and write masks
`define PSFD_RST_FAST_DISABLE    8'h00
`define PSFD_RST_PIN_SELECT      8'h00
`define PSFD_RST_LOCK_CONTROL    8'h00
`define PSFD_RST_GLOBAL_ENABLE   8'h00
`define PSFD_MASK_FAST_DISABLE   8'hEF
`define PSFD_MASK_LOCK_CONTROL   8'h03
`define PSFD_MASK_GLOBAL_ENABLE  8'h01
// strap sync chain depth before the straps may be loaded
`define PSFD_STRAP_SETTLE        2'h2
`endif

// ==== src/psfd_pkg.sv ====
package psfd_pkg;
    typedef enum logic [1:0] {
        PSFD_IDLE   = 2'b00,
        PSFD_ACCESS = 2'b01
    } psfd_state_type;
    typedef logic [7:0] psfd_byte_type;
endpackage

// ==== src/psfd_lock_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// carries lock events between the top and the lock keeper
interface psfd_lock_if;
    logic set_req;
    logic clear_req;
    logic locked;
    modport keeper (input set_req, input clear_req, output locked);
    modport user   (output set_req, output clear_req, input locked);
endinterface // psfd_lock_if
`default_nettype wire

// ==== src/psfd_lock_keeper.sv ====
`timescale 1ns/10ps
`default_nettype none
module psfd_lock_keeper
    import psfd_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    psfd_lock_if.keeper lk
);
    // unlock clears lock
    // unlock wins over a set in the same cycle so software can recover
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk.locked <= 1'b0;
        end else if (lk.clear_req) begin
            lk.locked <= 1'b0;
        end else if (lk.set_req) begin
            lk.locked <= 1'b1;
        end
    end

    property p_unlock_clears;
        @(posedge pclk) disable iff (!presetn)
        lk.clear_req |=> !lk.locked;
    endproperty
    a_unlock_clears: assert property (p_unlock_clears)
        else $error("lock stayed set after unlock");

    property p_lock_sticky;
        @(posedge pclk) disable iff (!presetn)
        (lk.locked && !lk.clear_req) |=> lk.locked;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock dropped without unlock");
endmodule // psfd_lock_keeper
`default_nettype wire

// ==== testbench/tb_psfd_cfg.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "psfd_params.svh"
module tb_psfd_cfg import psfd_pkg::*;;
    localparam logic [11:0] a_ps = `PSFD_ADDR_PIN_SELECT;
    localparam logic [11:0] a_fd = `PSFD_ADDR_FAST_DISABLE;
    localparam logic [11:0] a_lc = `PSFD_ADDR_LOCK_CONTROL;
    localparam logic [11:0] a_ge = `PSFD_ADDR_GLOBAL_ENABLE;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        main_reset_n = 1'b1;
    logic        strap_cnf0 = 1'b1;
    logic        strap_cnf1 = 1'b0;
    logic        strap_cnf2 = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [3:0]  module_activate = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  module_enable;
    logic        global_enable_bit;
    logic [7:0]  pin_select;
    logic [31:0] rdat;
    logic        rerr;
    int          n_fail = 0;
    int          cmp_count = 0;

    psfd_cfg dut_u (
        .pclk(pclk), .presetn(presetn), .main_reset_n(main_reset_n),
        .strap_cnf0(strap_cnf0), .strap_cnf1(strap_cnf1),
        .strap_cnf2(strap_cnf2), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .module_activate(module_activate), .module_enable(module_enable),
        .global_enable_bit(global_enable_bit), .pin_select(pin_select)
    );

    always #12.5 pclk = ~pclk;

    task automatic finish_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // no limit here: a slave that never answers is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, 4'hF);
        chk(rdat, {24'h00_0000, e});
    endtask

    task automatic pulse_reset(input bit main);
        if (main)
            main_reset_n <= 1'b0;
        else
            presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        main_reset_n <= 1'b1;
        presetn <= 1'b1;
        // leave room for strap sync and reload
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        #(25 * 4000);
        n_fail++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rd_chk(a_fd, 8'h00);
        chk(32'(rerr), 32'h0000_0000);
        rd_chk(a_lc, 8'h00);
        rd_chk(a_ge, 8'h00);
        rd_chk(a_ps, 8'h01);
        wr(a_ps, 8'hF0);
        rd_chk(a_ps, 8'hF0);
        chk({24'h00_0000, pin_select}, 32'h0000_00F0);
        wr(a_fd, 8'h7F);
        rd_chk(a_fd, 8'h6F);
        @(negedge pclk);
        chk({28'h000_0000, module_enable}, 32'h0000_0000);
        wr(a_fd, 8'h05);
        repeat (2) @(negedge pclk);
        chk({28'h000_0000, module_enable}, 32'h0000_000A);
        // a module without activation stays off; of the activated ones, module 0 stays forced off and module 1 is on
        @(posedge pclk);
        module_activate <= 4'h3;
        repeat (2) @(negedge pclk);
        chk({28'h000_0000, module_enable}, 32'h0000_0002);
        wr(a_ge, 8'h01);
        rd_chk(a_ge, 8'h01);
        chk(32'(global_enable_bit), 32'h0000_0001);
        // lock, then try to undo force-offs; scratch stays writable
        wr(a_fd, 8'h85);
        wr(a_fd, 8'h60);
        rd_chk(a_fd, 8'hE5);
        wr(a_ge, 8'h00);
        rd_chk(a_ge, 8'h01);
        wr(a_lc, 8'h02);
        rd_chk(a_fd, 8'h65);
        rd_chk(a_lc, 8'h00);
        wr(a_fd, 8'h00);
        rd_chk(a_fd, 8'h00);
        apb(1'b0, 12'h000, 8'h00, 4'hF);
        chk(32'(rerr), 32'h0000_0001);
        apb(1'b1, a_fd, 8'h0F, 4'h0);
        rd_chk(a_fd, 8'h00);
        wr(a_fd, 8'h80);
        pulse_reset(1'b1);
        rd_chk(a_fd, 8'h00);
        wr(a_lc, 8'h01);
        wr(a_fd, 8'h80);
        pulse_reset(1'b1);
        rd_chk(a_fd, 8'h80);
        strap_cnf2 <= 1'b0;
        pulse_reset(1'b0);
        rd_chk(a_fd, 8'h00);
        rd_chk(a_lc, 8'h00);
        rd_chk(a_ps, 8'h70);
        finish_test;
    end
endmodule // tb_psfd_cfg
`default_nettype wire
